// ---- design/gpr_file.sv ----
// gpr_file: 32 x 32-bit register file, two read ports, one write port
// assumes reads are combinational and the write lands on the rising clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module gpr_file (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire pipe_pkg::ridx_t wr_idx,
   input wire pipe_pkg::word_t wr_data,
   input wire pipe_pkg::ridx_t ra_idx,
   output pipe_pkg::word_t ra_data,
   input wire pipe_pkg::ridx_t rb_idx,
   output pipe_pkg::word_t rb_data
);
   import pipe_pkg::*;

   word_t regs [NREG];

   // no reset: contents are unknown until software writes them
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         regs[wr_idx] <= wr_data;
      end
   end

   // write-through closes the gap between writeback and decode
   assign ra_data = (wr_en && wr_idx == ra_idx) ? wr_data : regs[ra_idx];
   assign rb_data = (wr_en && wr_idx == rb_idx) ? wr_data : regs[rb_idx];

   property p_wb_store;
      @(posedge clk_sys) disable iff (!reset_n)
      wr_en |=> regs[$past(wr_idx)] == $past(wr_data);
   endproperty
   a_wb_store:
   assert property (p_wb_store) else $error("register write not stored");

   property p_write_through;
      @(posedge clk_sys) disable iff (!reset_n)
      (wr_en && wr_idx == ra_idx) |-> ra_data == wr_data;
   endproperty
   a_write_through:
   assert property (p_write_through) else $error("decode read missed writeback value");
endmodule // gpr_file
`default_nettype wire

// ---- design/pipe_core.sv ----
// pipe_core: five-stage integer pipeline control with bypass and interlock
// assumes instruction and data memories answer in the cycle the address stands
//
// Operation
// - five stages in order, address to writeback
// - forward results to decode before writeback
// - stall on hazards bypass cannot cover
// - address stage drives next fetch address
// - decode takes operands from file or bypass
// - static prediction of pc-relative branches
// - simple ops finish in execute, forwarded there
// - loads, stores, multiply, shift use memory stage
// - writeback stores result in destination register
// - 32 registers of 32 bits, 32-bit instructions
// - separate instruction and data ports, concurrent
// - register 0 is ordinary writable storage
// - call writes return address to register 29
// - exception saves pc in register 30
// - breakpoint saves pc in register 31
// - register file is not cleared by reset
// - 8, 16, 32-bit signed and unsigned operands
// - pc low two bits always zero
`timescale 1ns/1ps
`default_nettype none
module pipe_core (
   input wire logic clk_sys,
   input wire logic reset_n,
   output var pipe_pkg::word_t imem_addr,
   input wire pipe_pkg::word_t imem_rdata,
   output var pipe_pkg::word_t dmem_addr,
   output var logic dmem_rd_en,
   output var logic dmem_wr_en,
   output var logic [3:0] dmem_be,
   output var pipe_pkg::word_t dmem_wdata,
   input wire pipe_pkg::word_t dmem_rdata,
   input wire logic exc_req,
   input wire logic brk_req
);
   import pipe_pkg::*;

   // decode stage
   logic d_valid_q;
   word_t d_ir_q, d_pc_q;
   opc_t d_op;
   ridx_t d_rd, d_ra, d_rb;
   word_t d_imm, d_tgt, d_av, d_bv, rf_a, rf_b;
   logic d_wr, d_pred, d_redir, stall;

   // execute stage
   logic x_valid_q, x_wr_q, x_pred_q;
   opc_t x_op_q;
   ridx_t x_rd_q;
   word_t x_a_q, x_b_q, x_imm_q, x_pc_q;
   word_t x_res, x_tgt, x_addr, x_fix;
   logic x_cond, x_mis, x_redir, ex_take, x_wr_e, x_fwd_ok, x_late;
   ridx_t x_rd_e;

   // memory and writeback stages
   logic m_valid_q, m_wr_q;
   opc_t m_op_q;
   ridx_t m_rd_q;
   word_t m_res_q, m_a_q, m_b_q, m_val;
   logic w_wr_q;
   ridx_t w_rd_q;
   word_t w_res_q;

   word_t a_next;

   // newest in-flight producer wins; the file already covers writeback
   function automatic word_t operand(input ridx_t idx, input word_t rf);
      if (x_fwd_ok && x_rd_e == idx) begin
         return x_res;
      end else if (m_valid_q && m_wr_q && m_rd_q == idx) begin
         return m_val;
      end
      return rf;
   endfunction

   function automatic logic late_hit(input ridx_t idx);
      return x_late && x_rd_e == idx;
   endfunction

   // decode
   assign d_op = opc_t'(d_ir_q[OPC_LSB +: 6]);
   assign d_ra = d_ir_q[RA_LSB +: 5];
   assign d_rb = d_ir_q[RB_LSB +: 5];
   assign d_rd = (d_op == OP_CALL) ? LINK_REG : d_ir_q[RD_LSB +: 5];
   assign d_wr = writes_rd(d_op) || d_op == OP_CALL;
   assign d_imm = {{(32 - IMM_W){d_ir_q[IMM_W - 1]}}, d_ir_q[IMM_W - 1:0]};
   assign d_tgt = d_pc_q + {d_imm[29:0], 2'b00};

   always_comb begin
      d_av = operand(d_ra, rf_a);
      d_bv = operand(d_rb, rf_b);
   end

   // a multiply, shift or load one stage ahead is not ready until memory
   always_comb begin
      stall = d_valid_q && !x_redir &&
              (late_hit(d_ra) || (uses_rb(d_op) && late_hit(d_rb)));
   end

   // backward taken, forward not taken
   assign d_pred = is_branch(d_op) && d_imm[31];
   assign d_redir = d_valid_q && !stall && !x_redir && (d_pred || d_op == OP_CALL);

   // execute
   always_comb begin
      x_res = x_a_q + x_b_q;
      case (x_op_q)
         OP_SUB: x_res = x_a_q - x_b_q;
         OP_AND: x_res = x_a_q & x_b_q;
         OP_OR: x_res = x_a_q | x_b_q;
         OP_XOR: x_res = x_a_q ^ x_b_q;
         OP_ADDI: x_res = x_a_q + x_imm_q;
         OP_CALL: x_res = x_pc_q + INSN_BYTES;
         default: x_res = x_a_q + x_b_q;
      endcase
      if (ex_take) begin
         x_res = x_pc_q;
      end
   end

   assign x_addr = x_a_q + x_imm_q;
   assign x_tgt = x_pc_q + {x_imm_q[29:0], 2'b00};
   assign x_cond = (x_op_q == OP_BEQ) ? (x_a_q == x_b_q) : (x_a_q != x_b_q);

   // an exception replaces the instruction in execute; a breakpoint outranks it
   assign ex_take = x_valid_q && (exc_req || brk_req);
   assign x_mis = x_valid_q && is_branch(x_op_q) && (x_cond != x_pred_q);
   assign x_redir = ex_take || x_mis;
   assign x_rd_e = !ex_take ? x_rd_q : (brk_req ? BRK_REG : EXC_REG);
   assign x_wr_e = ex_take || x_wr_q;
   assign x_fwd_ok = x_valid_q && x_wr_e && (ex_take || !is_cplx(x_op_q));
   assign x_late = x_valid_q && x_wr_e && !ex_take && is_cplx(x_op_q);

   always_comb begin
      if (ex_take) begin
         x_fix = brk_req ? BRK_VEC : EXC_VEC;
      end else if (x_cond) begin
         x_fix = x_tgt;
      end else begin
         x_fix = x_pc_q + INSN_BYTES;
      end
   end

   // address stage: later stages override earlier guesses
   always_comb begin
      a_next = imem_addr + INSN_BYTES;
      if (stall) begin
         a_next = imem_addr;
      end
      if (d_redir) begin
         a_next = d_tgt;
      end
      if (x_redir) begin
         a_next = x_fix;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         imem_addr <= RESET_PC;
      end else begin
         imem_addr <= {a_next[31:2], 2'b00};
      end
   end

   // fetch to decode: the word at imem_addr is captured at the edge
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         d_valid_q <= 1'b0;
         d_ir_q <= '0;
         d_pc_q <= '0;
      end else if (x_redir || d_redir) begin
         d_valid_q <= 1'b0;
      end else if (!stall) begin
         d_valid_q <= 1'b1;
         d_ir_q <= imem_rdata;
         d_pc_q <= imem_addr;
      end
   end

   // decode to execute; a stall leaves a bubble here
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         x_valid_q <= 1'b0;
         x_op_q <= OP_ADD;
         x_rd_q <= '0;
         x_wr_q <= 1'b0;
         x_pred_q <= 1'b0;
         x_a_q <= '0;
         x_b_q <= '0;
         x_imm_q <= '0;
         x_pc_q <= '0;
      end else begin
         x_valid_q <= d_valid_q && !x_redir && !stall;
         x_op_q <= d_op;
         x_rd_q <= d_rd;
         x_wr_q <= d_wr;
         x_pred_q <= d_pred;
         x_a_q <= d_av;
         x_b_q <= d_bv;
         x_imm_q <= d_imm;
         x_pc_q <= d_pc_q;
      end
   end

   // execute to memory
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         m_valid_q <= 1'b0;
         m_op_q <= OP_ADD;
         m_rd_q <= '0;
         m_wr_q <= 1'b0;
         m_res_q <= '0;
         m_a_q <= '0;
         m_b_q <= '0;
      end else begin
         m_valid_q <= x_valid_q;
         m_op_q <= ex_take ? OP_ADD : x_op_q;
         m_rd_q <= x_rd_e;
         m_wr_q <= x_wr_e;
         m_res_q <= x_res;
         m_a_q <= x_a_q;
         m_b_q <= x_b_q;
      end
   end

   // data port runs alongside the fetch port every cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dmem_rd_en <= 1'b0;
         dmem_wr_en <= 1'b0;
         dmem_addr <= '0;
         dmem_be <= 4'h0;
         dmem_wdata <= '0;
      end else begin
         dmem_rd_en <= x_valid_q && !ex_take && is_load(x_op_q);
         dmem_wr_en <= x_valid_q && !ex_take && is_store(x_op_q);
         dmem_addr <= x_addr;
         case (x_op_q)
            OP_SB: begin
               dmem_be <= 4'h1 << x_addr[1:0];
               dmem_wdata <= {4{x_b_q[7:0]}};
            end
            OP_SH: begin
               dmem_be <= x_addr[1] ? 4'hC : 4'h3;
               dmem_wdata <= {2{x_b_q[15:0]}};
            end
            default: begin
               dmem_be <= 4'hF;
               dmem_wdata <= x_b_q;
            end
         endcase
      end
   end

   // memory stage as second execution stage
   always_comb begin
      case (m_op_q)
         OP_MUL: m_val = m_a_q * m_b_q;
         OP_SHL: m_val = m_a_q << m_b_q[4:0];
         OP_SHR: m_val = m_a_q >> m_b_q[4:0];
         default: begin
            if (is_load(m_op_q)) begin
               m_val = load_ext(dmem_rdata, dmem_addr[1:0], m_op_q);
            end else begin
               m_val = m_res_q;
            end
         end
      endcase
   end

   // memory to writeback
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         w_wr_q <= 1'b0;
         w_rd_q <= '0;
         w_res_q <= '0;
      end else begin
         w_wr_q <= m_valid_q && m_wr_q;
         w_rd_q <= m_rd_q;
         w_res_q <= m_val;
      end
   end

   gpr_file gpr_file_i (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wr_en(w_wr_q),
      .wr_idx(w_rd_q),
      .wr_data(w_res_q),
      .ra_idx(d_ra),
      .ra_data(rf_a),
      .rb_idx(d_rb),
      .rb_data(rf_b)
   );

   property p_pc_align;
      @(posedge clk_sys) disable iff (!reset_n)
      imem_addr[1:0] == 2'b00;
   endproperty
   a_pc_align:
   assert property (p_pc_align) else $error("fetch address not word aligned");

   property p_stall_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      stall |=> imem_addr == $past(imem_addr) && !x_valid_q && !stall;
   endproperty
   a_stall_hold:
   assert property (p_stall_hold) else $error("interlock did not hold for one bubble");

   property p_fwd_exec;
      @(posedge clk_sys) disable iff (!reset_n)
      (d_valid_q && !stall && !x_redir && x_fwd_ok && x_rd_e == d_ra)
      |=> x_a_q == $past(x_res);
   endproperty
   a_fwd_exec:
   assert property (p_fwd_exec) else $error("execute result not bypassed");

   property p_order;
      @(posedge clk_sys) disable iff (!reset_n)
      (d_valid_q && !stall && !x_redir) |=> x_valid_q ##1 m_valid_q;
   endproperty
   a_order:
   assert property (p_order) else $error("stage sequence broken");

   property p_mul_late;
      @(posedge clk_sys) disable iff (!reset_n)
      (m_valid_q && m_op_q == OP_MUL && m_wr_q) |=> w_wr_q && w_res_q == $past(m_a_q) * $past(m_b_q);
   endproperty
   a_mul_late:
   assert property (p_mul_late) else $error("multiply result wrong at writeback");

   property p_load_port;
      @(posedge clk_sys) disable iff (!reset_n)
      (x_valid_q && !ex_take && is_load(x_op_q)) |=> dmem_rd_en && dmem_addr == $past(x_addr);
   endproperty
   a_load_port:
   assert property (p_load_port) else $error("load not issued on data port");

   property p_predict;
      @(posedge clk_sys) disable iff (!reset_n)
      (d_valid_q && !stall && !x_redir && is_branch(d_op) && d_imm[31]) |=> imem_addr == $past(d_tgt);
   endproperty
   a_predict:
   assert property (p_predict) else $error("backward branch not predicted taken");

   property p_call_link;
      @(posedge clk_sys) disable iff (!reset_n)
      (x_valid_q && !ex_take && x_op_q == OP_CALL)
      |=> m_rd_q == LINK_REG && m_wr_q && m_res_q == $past(x_pc_q) + INSN_BYTES;
   endproperty
   a_call_link:
   assert property (p_call_link) else $error("call did not link to register 29");

   property p_exc_save;
      @(posedge clk_sys) disable iff (!reset_n)
      (x_valid_q && exc_req && !brk_req)
      |=> m_rd_q == EXC_REG && m_wr_q && m_res_q == $past(x_pc_q) && imem_addr == EXC_VEC;
   endproperty
   a_exc_save:
   assert property (p_exc_save) else $error("exception pc not saved to register 30");

   property p_brk_save;
      @(posedge clk_sys) disable iff (!reset_n)
      (x_valid_q && brk_req)
      |=> m_rd_q == BRK_REG && m_wr_q && m_res_q == $past(x_pc_q) && imem_addr == BRK_VEC;
   endproperty
   a_brk_save:
   assert property (p_brk_save) else $error("breakpoint pc not saved to register 31");
endmodule // pipe_core
`default_nettype wire

// ---- inc/pipe_pkg.sv ----
// pipe_pkg: shared widths, instruction fields, opcodes, vectors and helpers
// assumes a single clk_sys domain; the instruction encoding here is local to this core
package pipe_pkg;
   typedef logic [31:0] word_t;
   typedef logic [4:0] ridx_t;
   typedef logic [5:0] opc_t;

   localparam int NREG = 32;
   localparam int OPC_LSB = 26;
   localparam int RD_LSB = 21;
   localparam int RA_LSB = 16;
   localparam int RB_LSB = 11;
   localparam int IMM_W = 16;

   localparam ridx_t LINK_REG = 5'h1D;
   localparam ridx_t EXC_REG = 5'h1E;
   localparam ridx_t BRK_REG = 5'h1F;
   localparam word_t RESET_PC = 32'h00000000;
   localparam word_t EXC_VEC = 32'h00000020;
   localparam word_t BRK_VEC = 32'h00000040;
   localparam word_t INSN_BYTES = 32'h00000004;

   localparam opc_t OP_ADD = 6'h00;
   localparam opc_t OP_SUB = 6'h01;
   localparam opc_t OP_AND = 6'h02;
   localparam opc_t OP_OR = 6'h03;
   localparam opc_t OP_XOR = 6'h04;
   localparam opc_t OP_ADDI = 6'h05;
   localparam opc_t OP_SHL = 6'h06;
   localparam opc_t OP_SHR = 6'h07;
   localparam opc_t OP_MUL = 6'h08;
   localparam opc_t OP_LB = 6'h09;
   localparam opc_t OP_LBU = 6'h0A;
   localparam opc_t OP_LH = 6'h0B;
   localparam opc_t OP_LHU = 6'h0C;
   localparam opc_t OP_LW = 6'h0D;
   localparam opc_t OP_SB = 6'h0E;
   localparam opc_t OP_SH = 6'h0F;
   localparam opc_t OP_SW = 6'h10;
   localparam opc_t OP_BEQ = 6'h11;
   localparam opc_t OP_BNE = 6'h12;
   localparam opc_t OP_CALL = 6'h13;

   function automatic logic is_load(input opc_t o);
      return o inside {OP_LB, OP_LBU, OP_LH, OP_LHU, OP_LW};
   endfunction

   function automatic logic is_store(input opc_t o);
      return o inside {OP_SB, OP_SH, OP_SW};
   endfunction

   function automatic logic is_branch(input opc_t o);
      return o inside {OP_BEQ, OP_BNE};
   endfunction

   // results that are only final at the end of the memory stage
   function automatic logic is_cplx(input opc_t o);
      return is_load(o) || (o inside {OP_MUL, OP_SHL, OP_SHR});
   endfunction

   function automatic logic writes_rd(input opc_t o);
      return o <= OP_LW;
   endfunction

   function automatic logic uses_rb(input opc_t o);
      return !(is_load(o) || (o inside {OP_ADDI, OP_CALL}));
   endfunction

   // little-endian lane pick, then zero or sign extension
   function automatic word_t load_ext(input word_t w, input logic [1:0] lane, input opc_t o);
      word_t s;
      s = w >> {lane, 3'b000};
      case (o)
         OP_LB: return {{24{s[7]}}, s[7:0]};
         OP_LBU: return {24'h000000, s[7:0]};
         OP_LH: return {{16{s[15]}}, s[15:0]};
         OP_LHU: return {16'h0000, s[15:0]};
         default: return w;
      endcase
   endfunction
endpackage

// ---- testbench/mem_model.sv ----
// mem_model: instruction and data memories standing on the far side of pipe_core
// assumes answers come in the same cycle the address stands; 256 words each, low addresses only
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic clk_sys,
   input wire pipe_pkg::word_t imem_addr,
   output pipe_pkg::word_t imem_rdata,
   input wire pipe_pkg::word_t dmem_addr,
   input wire logic dmem_rd_en,
   input wire logic dmem_wr_en,
   input wire logic [3:0] dmem_be,
   input wire pipe_pkg::word_t dmem_wdata,
   output pipe_pkg::word_t dmem_rdata
);
   import pipe_pkg::*;
   word_t imem [256];
   word_t dmem [256];
   word_t last_q;
   int i;
   initial begin
      for (i = 0; i < 256; i++) begin
         dmem[i] = 32'hA5A5A5A5;
      end
      last_q = 32'h00000000;
   end
   // both ports answer independently, so fetch and data access share a cycle
   assign imem_rdata = imem[imem_addr[9:2]];
   // an idle data bus shows the inverse of the last word, never a stale copy
   assign dmem_rdata = dmem_rd_en ? dmem[dmem_addr[9:2]] : ~last_q;
   always @(posedge clk_sys) begin
      if (dmem_rd_en) begin
         last_q <= dmem[dmem_addr[9:2]];
      end
      if (dmem_wr_en) begin
         for (int k = 0; k < 4; k++) begin
            if (dmem_be[k]) begin
               dmem[dmem_addr[9:2]][k*8 +: 8] <= dmem_wdata[k*8 +: 8];
            end
         end
      end
   end
endmodule // mem_model
`default_nettype wire

// ---- testbench/pipe_core_tb.sv ----
// pipe_core_tb: runs short programs through pipe_core and inspects stored results
// assumes mem_model as far side; registers are observed only through stores
`timescale 1ns/1ps
`default_nettype none
module pipe_core_tb;
   import pipe_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic exc_req = 1'b0;
   logic brk_req = 1'b0;
   word_t imem_addr, imem_rdata, dmem_addr, dmem_wdata, dmem_rdata;
   logic dmem_rd_en, dmem_wr_en;
   logic [3:0] dmem_be;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   int pc_w;
   localparam word_t NOP = 32'hFC000000;

   pipe_core pipe_core_i (.clk_sys(clk_sys), .reset_n(reset_n), .imem_addr(imem_addr),
      .imem_rdata(imem_rdata), .dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en),
      .dmem_wr_en(dmem_wr_en), .dmem_be(dmem_be), .dmem_wdata(dmem_wdata),
      .dmem_rdata(dmem_rdata), .exc_req(exc_req), .brk_req(brk_req));
   mem_model mem_model_i (.clk_sys(clk_sys), .imem_addr(imem_addr), .imem_rdata(imem_rdata),
      .dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en), .dmem_wr_en(dmem_wr_en),
      .dmem_be(dmem_be), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

   always #5 clk_sys = ~clk_sys;

   task automatic end_sim();
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic ck(input word_t got, input word_t exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // limit sized for six short runs of under a hundred cycles each
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         $display("[ERR] %0t run did not finish", $time);
         end_sim();
      end
   end

   always @(negedge clk_sys) begin
      if (reset_n) begin
         ck({30'h0, imem_addr[1:0]}, 32'h0);
      end
   end

   function automatic word_t rr(input opc_t o, input ridx_t d, input ridx_t a, input ridx_t b);
      return {o, d, a, b, 11'h000};
   endfunction
   function automatic word_t ri(input opc_t o, input ridx_t d, input ridx_t a, input logic [15:0] m);
      return {o, d, a, m};
   endfunction
   // store with base zero: the source index shares the offset bits, only off[9:2] picks the word
   function automatic word_t st(input opc_t o, input ridx_t b, input logic [10:0] off);
      return {o, 5'h00, 5'h00, b, off};
   endfunction
   function automatic word_t alu(input opc_t o, input word_t a, input word_t b);
      case (o)
         OP_ADD: return a + b;
         OP_SUB: return a - b;
         OP_AND: return a & b;
         OP_OR: return a | b;
         OP_XOR: return a ^ b;
         OP_MUL: return a * b;
         OP_SHL: return a << b[4:0];
         OP_SHR: return a >> b[4:0];
         default: return 32'h0;
      endcase
   endfunction

   task automatic emit(input word_t w);
      mem_model_i.imem[pc_w] = w;
      pc_w++;
   endtask

   // the file holds unknowns after reset; a call at zero gives a known link value to clear with
   task automatic prep(input logic prelude);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      for (int i = 0; i < 256; i++) begin
         mem_model_i.imem[i] = NOP;
      end
      pc_w = 0;
      if (prelude) begin
         emit(ri(OP_CALL, 5'h00, 5'h00, 16'h0001));
         emit(rr(OP_SUB, 5'h00, LINK_REG, LINK_REG));
      end
   endtask

   task automatic run(input int n, input word_t a, input logic e, input logic b);
      @(negedge clk_sys);
      ck(imem_addr, RESET_PC);
      @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      ck(imem_addr, RESET_PC);
      @(negedge clk_sys);
      ck(imem_addr, INSN_BYTES);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys);
         if ((e || b) && imem_addr === a) begin
            @(posedge clk_sys);
            @(posedge clk_sys);
            exc_req <= e;
            brk_req <= b;
            @(posedge clk_sys);
            exc_req <= 1'b0;
            brk_req <= 1'b0;
            e = 1'b0;
            b = 1'b0;
         end
      end
   endtask

   task automatic t_alu();
      opc_t ops [5] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR};
      prep(1'b1);
      emit(ri(OP_ADDI, 5'h01, 5'h00, 16'h0123));
      emit(ri(OP_ADDI, 5'h07, 5'h00, 16'hFFF0));
      for (int k = 0; k < 5; k++) begin
         emit(rr(ops[k], 5'(2 + k), 5'h01, 5'h07));
         emit(st(OP_SW, 5'(2 + k), 11'(12'h200 + 4 * k)));
      end
      emit(ri(OP_ADDI, 5'h0A, 5'h00, 16'h0005));
      emit(NOP);
      emit(NOP);
      emit(rr(OP_ADD, 5'h0B, 5'h0A, 5'h0A));
      emit(st(OP_SW, 5'h0B, 11'h220));
      emit(st(OP_SW, LINK_REG, 11'h224));
      emit(st(OP_SW, 5'h00, 11'h228));
      run(60, 32'h0, 1'b0, 1'b0);
      for (int k = 0; k < 5; k++) begin
         ck(mem_model_i.dmem[8'h80 + k], alu(ops[k], 32'h123, 32'hFFFFFFF0));
      end
      ck(mem_model_i.dmem[8'h88], 32'h0000000A);
      ck(mem_model_i.dmem[8'h89], 32'h00000004);
      ck(mem_model_i.dmem[8'h8A], 32'h00000000);
   endtask

   task automatic t_keep();
      prep(1'b0);
      emit(st(OP_SW, 5'h01, 11'h22C));
      run(20, 32'h0, 1'b0, 1'b0);
      ck(mem_model_i.dmem[8'h8B], 32'h00000123);
   endtask

   task automatic t_cplx();
      opc_t cops [3] = '{OP_MUL, OP_SHL, OP_SHR};
      opc_t lops [6] = '{OP_LB, OP_LBU, OP_LB, OP_LH, OP_LHU, OP_LW};
      logic [15:0] offs [6] = '{16'h0100, 16'h0101, 16'h0103, 16'h0102, 16'h0102, 16'h0100};
      word_t lexp [6] = '{32'hFFFFFF82, 32'h0000007F, 32'hFFFFFF80, 32'hFFFF80F1,
         32'h000080F1, 32'h80F17F82};
      prep(1'b1);
      mem_model_i.dmem[8'h40] = 32'h80F17F82;
      emit(ri(OP_ADDI, 5'h01, 5'h00, 16'h0123));
      emit(ri(OP_ADDI, 5'h07, 5'h00, 16'h0003));
      for (int k = 0; k < 3; k++) begin
         emit(rr(cops[k], 5'(2 + k), 5'h01, 5'h07));
         emit(st(OP_SW, 5'(2 + k), 11'(12'h240 + 4 * k)));
      end
      for (int k = 0; k < 6; k++) begin
         emit(ri(lops[k], 5'h08, 5'h00, offs[k]));
         emit(st(OP_SW, 5'h08, 11'(12'h260 + 4 * k)));
      end
      emit(ri(OP_ADDI, 5'h09, 5'h00, 16'h5AC3));
      emit(st(OP_SB, 5'h09, 11'h105));
      emit(st(OP_SH, 5'h09, 11'h10A));
      run(90, 32'h0, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++) begin
         ck(mem_model_i.dmem[8'h90 + k], alu(cops[k], 32'h123, 32'h3));
      end
      for (int k = 0; k < 6; k++) begin
         ck(mem_model_i.dmem[8'h98 + k], lexp[k]);
      end
      ck(mem_model_i.dmem[8'h41], 32'hA5A5C3A5);
      ck(mem_model_i.dmem[8'h42], 32'h5AC3A5A5);
   endtask

   // branch compare index shares imm[15:11], so negative offsets compare against register 31
   task automatic t_branch();
      prep(1'b1);
      emit(ri(OP_ADDI, 5'h1F, 5'h00, 16'h0000));
      emit(ri(OP_ADDI, 5'h01, 5'h00, 16'h0003));
      emit(ri(OP_ADDI, 5'h02, 5'h00, 16'h0000));
      emit(ri(OP_ADDI, 5'h09, 5'h00, 16'h0077));
      emit(ri(OP_ADDI, 5'h01, 5'h01, 16'hFFFF));
      emit(ri(OP_ADDI, 5'h02, 5'h02, 16'h0005));
      emit(ri(OP_BNE, 5'h00, 5'h01, 16'hFFFE));
      emit(ri(OP_BEQ, 5'h00, 5'h00, 16'h0002));
      emit(ri(OP_ADDI, 5'h09, 5'h00, 16'h0011));
      emit(ri(OP_BNE, 5'h00, 5'h00, 16'hFFFF));
      emit(ri(OP_ADDI, 5'h02, 5'h02, 16'h0001));
      emit(st(OP_SW, 5'h02, 11'h280));
      emit(st(OP_SW, 5'h09, 11'h284));
      run(80, 32'h0, 1'b0, 1'b0);
      ck(mem_model_i.dmem[8'hA0], 32'h00000010);
      ck(mem_model_i.dmem[8'hA1], 32'h00000077);
   endtask

   task automatic t_exc(input logic both);
      prep(1'b1);
      mem_model_i.imem[EXC_VEC[9:2]] = st(OP_SW, EXC_REG, 11'h290);
      mem_model_i.imem[EXC_VEC[9:2] + 1] = ri(OP_BEQ, 5'h00, 5'h00, 16'h0000);
      mem_model_i.imem[BRK_VEC[9:2]] = st(OP_SW, BRK_REG, 11'h294);
      mem_model_i.imem[BRK_VEC[9:2] + 1] = ri(OP_BEQ, 5'h00, 5'h00, 16'h0000);
      run(50, 32'h00000010, 1'b1, both);
      if (both) begin
         ck(mem_model_i.dmem[8'hA5], 32'h00000010);
      end else begin
         ck(mem_model_i.dmem[8'hA4], 32'h00000010);
      end
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      t_alu();
      t_keep();
      t_cplx();
      t_branch();
      t_exc(1'b0);
      t_exc(1'b1);
      end_sim();
   end
endmodule // pipe_core_tb
`default_nettype wire
